// ---- ckg_params.svh ----
// constants of the clock generator control block
`ifndef CKG_PARAMS_SVH
`define CKG_PARAMS_SVH

// serial slave address, upper seven bits of the address byte
`define CKG_SLAVE_ADDR     7'h69
// number of implemented control bytes, id byte included
`define CKG_NUM_REGS       4'h7
`define CKG_LAST_REG_IDX   4'h6
// index of the first data byte after address, command and count bytes
`define CKG_FIRST_DATA_NUM 2'h3

// register 0 field positions
`define CKG_R0_TRISTATE    0
`define CKG_R0_SPREAD_EN   1
`define CKG_R0_CODE_MSB    2
`define CKG_R0_SOFT_SEL    3
`define CKG_R0_CODE_LO_LSB 4
`define CKG_R0_CODE_LO_MSB 6
`define CKG_R0_SPREAD_WIDE 7

// enable bit positions in registers 1 to 3
`define CKG_R1_HOST_LSB    1
`define CKG_R1_HOST_MSB    3
`define CKG_R2_BUS_LSB     0
`define CKG_R2_BUS_MSB     4
`define CKG_R3_MEM_LSB     0
`define CKG_R3_MEM_MSB     2

// latched strap read-back positions
`define CKG_R1_FS2_POS     7
`define CKG_R3_FS0_POS     6
`define CKG_R4_FS1_POS     3
`define CKG_R4_FS3_POS     1

// reset values
`define CKG_R0_RESET       8'h00
`define CKG_RX_RESET       8'hFF
// identity byte, value is arbitrary
`define CKG_CHIP_ID        8'h5A
`define CKG_UNMAPPED_READ  8'h00

`endif

// ---- ckg_pkg.sv ----
// types shared by the clock generator control block
package ckg_pkg;

  typedef enum logic [2:0] {
    CKG_S_IDLE,
    CKG_S_RX,
    CKG_S_RX_ACK,
    CKG_S_TX,
    CKG_S_TX_ACK
  } ckg_ser_state_t;

  typedef logic [7:0] ckg_byte_t;

endpackage

// ---- ckg_serial_slave.sv ----
// two-wire serial slave: address match, dummy bytes, sequential write and read
`timescale 1ns/1ps
`include "ckg_params.svh"

module ckg_serial_slave
  import ckg_pkg::*;
(
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  // serial pins
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_oe,
  // register access
  output logic           wr_en,
  output logic [3:0]     wr_idx,
  output ckg_byte_t      wr_data,
  output logic [3:0]     rd_idx,
  input  wire ckg_byte_t rd_data
);

  ckg_ser_state_t state_r;
  logic           scl_prev_r;
  logic           sda_prev_r;
  logic [3:0]     bit_cnt_r;
  logic [1:0]     byte_num_r;
  logic           rw_r;
  ckg_byte_t      shift_r;
  logic [3:0]     idx_r;

  wire scl_rise   = scl_in & ~scl_prev_r;
  wire scl_fall   = ~scl_in & scl_prev_r;
  wire start_cond = scl_in & scl_prev_r & sda_prev_r & ~sda_in;
  wire stop_cond  = scl_in & scl_prev_r & ~sda_prev_r & sda_in;
  wire byte_done  = scl_fall & (bit_cnt_r == 4'h8);
  wire addr_hit   = (shift_r[7:1] == `CKG_SLAVE_ADDR);
  wire is_data    = (byte_num_r == `CKG_FIRST_DATA_NUM);

  assign rd_idx = idx_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r    <= CKG_S_IDLE;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      bit_cnt_r  <= 4'h0;
      byte_num_r <= 2'h0;
      rw_r       <= 1'b0;
      shift_r    <= 8'h00;
      idx_r      <= 4'h0;
      sda_oe     <= 1'b0;
      wr_en      <= 1'b0;
      wr_idx     <= 4'h0;
      wr_data    <= 8'h00;
    end
    else
    begin
      scl_prev_r <= scl_in;
      sda_prev_r <= sda_in;
      wr_en      <= 1'b0;
      if (stop_cond)
      begin
        state_r <= CKG_S_IDLE;
        sda_oe  <= 1'b0;
      end
      else if (start_cond)
      begin
        state_r    <= CKG_S_RX;
        bit_cnt_r  <= 4'h0;
        byte_num_r <= 2'h0;
        idx_r      <= 4'h0;
        sda_oe     <= 1'b0;
      end
      else
      begin
        case (state_r)
          CKG_S_RX:
          begin
            if (scl_rise)
            begin
              shift_r   <= {shift_r[6:0], sda_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (byte_done)
            begin
              bit_cnt_r <= 4'h0;
              if (byte_num_r == 2'h0 && !addr_hit)
              begin
                state_r <= CKG_S_IDLE;
              end
              else
              begin
                state_r <= CKG_S_RX_ACK;
                sda_oe  <= 1'b1;
                if (byte_num_r == 2'h0)
                begin
                  rw_r <= shift_r[0];
                end
                if (is_data)
                begin
                  // bytes past the last register are acknowledged and dropped
                  wr_en   <= (idx_r <= `CKG_LAST_REG_IDX);
                  wr_idx  <= idx_r;
                  wr_data <= shift_r;
                  if (idx_r != 4'hF)
                  begin
                    idx_r <= idx_r + 4'h1;
                  end
                end
              end
            end
          end
          CKG_S_RX_ACK:
          begin
            if (scl_fall)
            begin
              if (rw_r && byte_num_r == 2'h0)
              begin
                state_r <= CKG_S_TX;
                shift_r <= rd_data;
                sda_oe  <= ~rd_data[7];
              end
              else
              begin
                state_r <= CKG_S_RX;
                sda_oe  <= 1'b0;
                if (!is_data)
                begin
                  byte_num_r <= byte_num_r + 2'h1;
                end
              end
            end
          end
          CKG_S_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_r == 4'h7)
              begin
                bit_cnt_r <= 4'h0;
                state_r   <= CKG_S_TX_ACK;
                sda_oe    <= 1'b0;
                if (idx_r != 4'hF)
                begin
                  idx_r <= idx_r + 4'h1;
                end
              end
              else
              begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r   <= {shift_r[6:0], 1'b0};
                sda_oe    <= ~shift_r[6];
              end
            end
          end
          CKG_S_TX_ACK:
          begin
            if (scl_rise && sda_in)
            begin
              state_r <= CKG_S_IDLE; // host ended the read with a nack
            end
            else if (scl_fall)
            begin
              state_r <= CKG_S_TX;
              shift_r <= rd_data;
              sda_oe  <= ~rd_data[7];
            end
          end
          default:
          begin
            state_r <= CKG_S_IDLE;
            sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ack_drives_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r == CKG_S_RX_ACK) |-> sda_oe)
    else $error("ack phase without data line pulled low");

  a_write_data_only: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_en |-> $past(byte_num_r) == `CKG_FIRST_DATA_NUM)
    else $error("register write from a dummy byte");

endmodule // ckg_serial_slave

// ---- ckg_clk_gate.sv ----
// glitch-free start and stop of one clock output group
`timescale 1ns/1ps

module ckg_clk_gate #(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // clock sources
  input  wire logic         fr_src,
  input  wire logic         clk_src,
  // run request per output
  input  wire logic [W-1:0] run_req,
  // gated outputs
  output logic [W-1:0]      clk_out
);

  logic         fr_prev_r;
  logic         src_prev_r;
  logic         armed_r;
  logic [W-1:0] en_r;

  wire fr_rise  = fr_src & ~fr_prev_r;
  wire src_fall = ~clk_src & src_prev_r;
  // the enable moves only while the source is low, so a started or
  // stopped output never shows a shortened high phase
  wire take     = armed_r & src_fall;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fr_prev_r  <= 1'b0;
      src_prev_r <= 1'b0;
      armed_r    <= 1'b0;
      en_r       <= '0;
      clk_out    <= '0;
    end
    else
    begin
      fr_prev_r  <= fr_src;
      src_prev_r <= clk_src;
      if (take)
      begin
        armed_r <= 1'b0;
        en_r    <= run_req;
      end
      else if (fr_rise)
      begin
        armed_r <= 1'b1;
      end
      clk_out <= {W{clk_src}} & en_r;
    end
  end

  a_gate_change_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    (en_r != $past(en_r)) |-> !$past(clk_src))
    else $error("gate changed while the source was high");

  a_gate_needs_arm: assert property (@(posedge sys_clk) disable iff (!nrst)
    (en_r != $past(en_r)) |-> $past(armed_r))
    else $error("gate changed without a bus clock rising edge first");

  a_stopped_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    (en_r == '0) |=> (clk_out == '0))
    else $error("disabled output toggled");

endmodule // ckg_clk_gate

// ---- ckg_ctrl_top.sv ----
// clock generator control: serial registers, frequency select, output gating
//
// How it works
// - mode strap latched after reset; strap 0 enables stop inputs, 1 drives reference
// - an output other than the free-running and reference clocks runs only when its enable bit and its stop input allow it
// - stopped clocks sit low and finish their high phase first, no runts
// - start and stop wait for bus clock rise, then the clock's own fall
// - host stop lows host and memory clocks, bus stop lows bus clocks
// - serial slave reads back the stored control bytes
// - all registers take defaults at reset; works with no serial access
// - data moves only with clock low; edges while high are start and stop
// - transfers are whole bytes, each followed by an acknowledge bit
// - write opens with start and the one matching address byte
// - each received byte is acknowledged by pulling data low, except an address byte that does not match
// - command and count bytes follow the address, acknowledged and ignored
// - later written bytes fill registers 0, 1, 2 upward until stop
// - read returns registers 0 upward straight after the address acknowledge
// - register 0 bit 7 picks spread depth: 0 narrow, 1 wide
// - register 0 bit 3 picks source: 0 straps, 1 software code
// - four-bit code decodes to fourteen distinct host frequencies and a bus divider
// - register 0 bit 1 enables spread modulation
// - register 0 bit 0 set puts every clock output in high impedance
// - register 0 resets to zero
// - an output with its enable bit clear stays low
// - latched strap copies read back inverted
// - straps latched once and index the same table as the software code
`timescale 1ns/1ps
`include "ckg_params.svh"

module ckg_ctrl_top
  import ckg_pkg::*;
(
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  // straps, sampled once after reset
  input  wire logic       mode_strap_in,
  input  wire logic [3:0] hw_freq_strap,
  // power management stop inputs, active low
  input  wire logic  host_stop_n,
  input  wire logic  bus_stop_n,
  // clock sources from the synthesizer
  input  wire logic  host_clk_src,
  input  wire logic  mem_clk_src,
  input  wire logic  bus_clk_src,
  input  wire logic  ref_clk_src,
  // serial control port
  input  wire logic  serial_clock_line,
  input  wire logic  serial_data_line_in,
  output logic       serial_data_line_out,
  output logic       serial_data_line_oe,
  // clock outputs
  output logic [2:0]  host_clock_out,
  output logic [11:0] mem_clock_out,
  output logic [4:0]  bus_clock_out,
  output logic        free_running_bus_clock,
  output logic        reference_clock_out,
  output logic        reference_clock_oe,
  output logic        clk_out_oe,
  // synthesizer settings
  output logic [3:0]  freq_code,
  output logic [13:0] host_freq_10khz,
  output logic        bus_div3,
  output logic        spread_en,
  output logic        spread_wide
);

  // ****************************************************************
  // frequency table, shared by straps and software code
  // ****************************************************************
  function automatic logic [13:0] freq_of(input logic [3:0] code);
    case (code)
      4'hF:    freq_of = 14'h1770;
      4'hE:    freq_of = 14'h1A18;
      4'hD:    freq_of = 14'h1B58;
      4'hC:    freq_of = 14'h2328;
      4'hB:    freq_of = 14'h1F40;
      4'hA:    freq_of = 14'h208A;
      4'h9:    freq_of = 14'h2535;
      4'h8:    freq_of = 14'h2724;
      4'h7:    freq_of = 14'h1D4C;
      4'h6:    freq_of = 14'h1F40;
      4'h5:    freq_of = 14'h208A;
      4'h4:    freq_of = 14'h2904;
      4'h3:    freq_of = 14'h2AF8;
      4'h2:    freq_of = 14'h2CEC;
      4'h1:    freq_of = 14'h2EE0;
      default: freq_of = 14'h3070;
    endcase
  endfunction

  // bus clock is host/2 for these codes, host/3 otherwise
  function automatic logic div3_of(input logic [3:0] code);
    case (code)
      4'hF, 4'hE, 4'hD, 4'h7, 4'h6, 4'h5: div3_of = 1'b0;
      default:                            div3_of = 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // straps
  // ****************************************************************
  logic       strap_done_r;
  logic       mode_r;
  logic [3:0] hw_code_r;

  // the pins are only caught after release, never under the async reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_done_r <= 1'b0;
      mode_r       <= 1'b0;
      hw_code_r    <= 4'h0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      mode_r       <= mode_strap_in;
      hw_code_r    <= hw_freq_strap;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic       wr_en;
  logic [3:0] wr_idx;
  ckg_byte_t  wr_data;
  logic [3:0] rd_idx;
  ckg_byte_t  rd_data;
  ckg_byte_t  reg0_r;
  ckg_byte_t  regs_r [1:5];

  // latched strap copies are read-only and shown inverted
  wire ckg_byte_t r1_view = {~hw_code_r[2], regs_r[1][6:0]};
  wire ckg_byte_t r3_view = {regs_r[3][7], ~hw_code_r[0], regs_r[3][5:0]};
  wire ckg_byte_t r4_view = {regs_r[4][7:4], ~hw_code_r[1], regs_r[4][2],
                             ~hw_code_r[3], regs_r[4][0]};

  always_comb
  begin
    case (rd_idx)
      4'h0:    rd_data = reg0_r;
      4'h1:    rd_data = r1_view;
      4'h2:    rd_data = regs_r[2];
      4'h3:    rd_data = r3_view;
      4'h4:    rd_data = r4_view;
      4'h5:    rd_data = regs_r[5];
      4'h6:    rd_data = `CKG_CHIP_ID;
      default: rd_data = `CKG_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg0_r <= `CKG_R0_RESET;
      for (int i = 1; i <= 5; i++)
      begin
        regs_r[i] <= `CKG_RX_RESET;
      end
    end
    else if (wr_en)
    begin
      // index 6 holds the identity byte and ignores writes
      if (wr_idx == 4'h0)
      begin
        reg0_r <= wr_data;
      end
      for (int i = 1; i <= 5; i++)
      begin
        if (wr_idx == 4'(i))
        begin
          regs_r[i] <= wr_data;
        end
      end
    end
  end

  ckg_serial_slave u_serial (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .scl_in  (serial_clock_line),
    .sda_in  (serial_data_line_in),
    .sda_oe  (serial_data_line_oe),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ****************************************************************
  // frequency and spread selection
  // ****************************************************************
  wire       soft_sel  = reg0_r[`CKG_R0_SOFT_SEL];
  wire [3:0] soft_code = {reg0_r[`CKG_R0_CODE_MSB],
                          reg0_r[`CKG_R0_CODE_LO_MSB:`CKG_R0_CODE_LO_LSB]};
  wire [3:0] sel_code  = soft_sel ? soft_code : hw_code_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      freq_code       <= 4'h0;
      host_freq_10khz <= 14'h0000;
      bus_div3        <= 1'b0;
      spread_en       <= 1'b0;
      spread_wide     <= 1'b0;
      clk_out_oe      <= 1'b0;
    end
    else
    begin
      freq_code       <= sel_code;
      host_freq_10khz <= freq_of(sel_code);
      bus_div3        <= div3_of(sel_code);
      spread_en       <= reg0_r[`CKG_R0_SPREAD_EN];
      spread_wide     <= reg0_r[`CKG_R0_SPREAD_WIDE];
      clk_out_oe      <= ~reg0_r[`CKG_R0_TRISTATE];
    end
  end

  // ****************************************************************
  // power management gating
  // ****************************************************************
  // with the strap at 1 the stop pins are clock outputs, so stops never apply
  wire host_run_ok = mode_r | host_stop_n;
  wire bus_run_ok  = mode_r | bus_stop_n;

  wire [2:0]  host_req = regs_r[1][`CKG_R1_HOST_MSB:`CKG_R1_HOST_LSB]
                         & {3{host_run_ok}};
  wire [2:0]  mem_grp  = regs_r[3][`CKG_R3_MEM_MSB:`CKG_R3_MEM_LSB];
  wire [11:0] mem_req  = {{4{mem_grp[2]}}, {4{mem_grp[1]}}, {4{mem_grp[0]}}}
                         & {12{host_run_ok}};
  wire [4:0]  bus_req  = regs_r[2][`CKG_R2_BUS_MSB:`CKG_R2_BUS_LSB]
                         & {5{bus_run_ok}};

  ckg_clk_gate #(.W(3)) u_host_gate (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .fr_src  (bus_clk_src),
    .clk_src (host_clk_src),
    .run_req (host_req),
    .clk_out (host_clock_out)
  );

  ckg_clk_gate #(.W(12)) u_mem_gate (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .fr_src  (bus_clk_src),
    .clk_src (mem_clk_src),
    .run_req (mem_req),
    .clk_out (mem_clock_out)
  );

  ckg_clk_gate #(.W(5)) u_bus_gate (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .fr_src  (bus_clk_src),
    .clk_src (bus_clk_src),
    .run_req (bus_req),
    .clk_out (bus_clock_out)
  );

  // free-running and reference outputs ignore the stop inputs
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      free_running_bus_clock <= 1'b0;
      reference_clock_out    <= 1'b0;
      reference_clock_oe     <= 1'b0;
      serial_data_line_out   <= 1'b0;
    end
    else
    begin
      free_running_bus_clock <= bus_clk_src;
      reference_clock_out    <= ref_clk_src & mode_r;
      reference_clock_oe     <= mode_r & strap_done_r
                                & ~reg0_r[`CKG_R0_TRISTATE];
      serial_data_line_out   <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_mode_one_runs: assert property (@(posedge sys_clk) disable iff (!nrst)
    (strap_done_r && mode_r) |-> (host_req == regs_r[1][`CKG_R1_HOST_MSB:`CKG_R1_HOST_LSB]
                                  && bus_req == regs_r[2][`CKG_R2_BUS_MSB:`CKG_R2_BUS_LSB]))
    else $error("stop input honoured with mode strap at one");

  a_host_stop_req: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!mode_r && !host_stop_n) |-> (host_req == 3'h0 && mem_req == 12'h000))
    else $error("host stop did not clear host and memory requests");

  a_bus_stop_req: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!mode_r && !bus_stop_n) |-> (bus_req == 5'h00))
    else $error("bus stop did not clear bus requests");

  a_reg0_default: assert property (@(posedge sys_clk) disable iff (!nrst)
    !strap_done_r |-> (reg0_r == `CKG_R0_RESET))
    else $error("register 0 not at its default after reset");

  a_tristate_oe: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg0_r[`CKG_R0_TRISTATE] && $stable(reg0_r)) |=> !clk_out_oe)
    else $error("outputs enabled while tristate bit set");

  a_hw_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!soft_sel && $stable(reg0_r) && $stable(hw_code_r)) |=> (freq_code == $past(hw_code_r)))
    else $error("hardware selection ignored the straps");

  a_soft_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    (soft_sel && $stable(reg0_r)) |=> (freq_code == $past(soft_code)))
    else $error("software code not applied");

  a_spread_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    $stable(reg0_r) |=> (spread_en == $past(reg0_r[`CKG_R0_SPREAD_EN])
                         && spread_wide == $past(reg0_r[`CKG_R0_SPREAD_WIDE])))
    else $error("spread settings do not follow register 0");

  a_strap_inverted: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rd_idx == 4'h1) |-> (rd_data[`CKG_R1_FS2_POS] == ~hw_code_r[2]))
    else $error("strap copy not inverted on read");

endmodule // ckg_ctrl_top

// ---- ckg_host_model.sv ----
// two-wire serial host controller model for the bench
`timescale 1ns/1ps
module ckg_host_model
  import ckg_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // serial pins, sda_oe high pulls data low
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ********
  // bus phases
  // ********
  // data only moves with the clock low; sampled just before the fall
  task automatic bit_x(input logic b, output logic r);
    sda_oe <= ~b;
    repeat (5) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (5) @(posedge sys_clk);
    r = sda;
    scl <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
  // s=1 start (clock left low), s=0 stop (clock left high)
  task automatic cond(input logic s);
    sda_oe <= ~s;
    repeat (5) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sda_oe <= s;
    repeat (5) @(posedge sys_clk);
    scl <= ~s;
    repeat (5) @(posedge sys_clk);
  endtask
  // whole byte, msb first, then the acknowledge bit
  task automatic xfer(input ckg_byte_t d, input logic ai, output ckg_byte_t q,
                      output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ai, ao);
  endtask
endmodule // ckg_host_model

// ---- clock_gen_serial_ctrl_pm_tb.sv ----
// self-checking bench of the clock generator control block
`timescale 1ns/1ps
module clock_gen_serial_ctrl_pm_tb
  import ckg_pkg::*;
;
  logic        sys_clk;
  logic        nrst = 1'b0;
  logic        mode_strap_in = 1'b0;
  logic [3:0]  hw_freq_strap = 4'hF;
  logic        host_stop_n = 1'b1;
  logic        bus_stop_n = 1'b1;
  logic [15:0] cyc = 16'h0000;
  logic        h_oe;
  logic        serial_clock_line;
  logic        serial_data_line_out;
  logic        serial_data_line_oe;
  logic [2:0]  host_clock_out;
  logic [11:0] mem_clock_out;
  logic [4:0]  bus_clock_out;
  logic        free_running_bus_clock;
  logic        reference_clock_out;
  logic        reference_clock_oe;
  logic        clk_out_oe;
  logic [3:0]  freq_code;
  logic [13:0] host_freq_10khz;
  logic        bus_div3;
  logic        spread_en;
  logic        spread_wide;
  ckg_byte_t   q;
  logic        a;
  logic [15:0] h, m, b, f, r;
  int          bad_count = 0;
  int          total_checks = 0;
  // sources switch on the rising edge through cyc
  wire logic host_clk_src = cyc[1];
  wire logic mem_clk_src = cyc[1];
  wire logic bus_clk_src = cyc[2];
  wire logic ref_clk_src = cyc[1];
  wire logic serial_data_line_in = ~(h_oe | serial_data_line_oe);
  ckg_ctrl_top dut_u (.sys_clk, .nrst, .mode_strap_in, .hw_freq_strap, .host_stop_n,
    .bus_stop_n, .host_clk_src, .mem_clk_src, .bus_clk_src, .ref_clk_src,
    .serial_clock_line, .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe,
    .host_clock_out, .mem_clock_out, .bus_clock_out, .free_running_bus_clock,
    .reference_clock_out, .reference_clock_oe, .clk_out_oe, .freq_code,
    .host_freq_10khz, .bus_div3, .spread_en, .spread_wide);
  ckg_host_model hm_u (.sys_clk, .sda(serial_data_line_in), .scl(serial_clock_line),
    .sda_oe(h_oe));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ********
  // checking
  // ********
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // high cycles of each group over 40 cycles; a running group gives 20
  task automatic hi_cnt();
    {h, m, b, f, r} = 80'h0;
    repeat (40)
    begin
      @(negedge sys_clk);
      h += |host_clock_out;
      m += |mem_clock_out;
      b += |bus_clock_out;
      f += free_running_bus_clock;
      r += reference_clock_out;
    end
  endtask
  // full write: address, two dummy bytes, then registers 0 and 1
  task automatic wr(input ckg_byte_t b0, input ckg_byte_t b1);
    hm_u.cond(1'b1);
    hm_u.xfer(8'hD2, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.xfer(8'h00, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.xfer(8'h5C, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.xfer(b0, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.xfer(b1, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.cond(1'b0);
    repeat (3) @(posedge sys_clk);
  endtask
  // ********
  // scenarios
  // ********
  task automatic s_reset();
    cmp(spread_en, 16'h0000);
    cmp(spread_wide, 16'h0000);
    cmp(clk_out_oe, 16'h0001);
    cmp(host_freq_10khz, 16'h1770);
    cmp(bus_div3, 16'h0000);
    cmp(reference_clock_oe, 16'h0000);
    cmp(reference_clock_out, 16'h0000);
    cmp(serial_data_line_out, 16'h0000);
  endtask
  task automatic s_stop();
    host_stop_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    hi_cnt();
    cmp(h, 16'h0000);
    cmp(m, 16'h0000);
    cmp(b, 16'h0014);
    cmp(f, 16'h0014);
    host_stop_n <= 1'b1;
    bus_stop_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    hi_cnt();
    cmp(m, 16'h0014);
    cmp(b, 16'h0000);
    bus_stop_n <= 1'b1;
  endtask
  task automatic s_write();
    wr(8'hCA, 8'hF1);
    cmp(spread_wide, 16'h0001);
    cmp(spread_en, 16'h0001);
    cmp(host_freq_10khz, 16'h2904);
    cmp(freq_code, 16'h0004);
    cmp(bus_div3, 16'h0001);
    repeat (20) @(posedge sys_clk);
    hi_cnt();
    cmp(h, 16'h0000);
    cmp(m, 16'h0014);
  endtask
  task automatic s_read();
    hm_u.cond(1'b1);
    hm_u.xfer(8'hD3, 1'b1, q, a);
    cmp(a, 16'h0000);
    hm_u.xfer(8'hFF, 1'b0, q, a);
    cmp(q, 16'h00CA);
    hm_u.xfer(8'hFF, 1'b1, q, a);
    cmp(q, 16'h0071);
    hm_u.cond(1'b0);
  endtask
  task automatic s_bad();
    hm_u.cond(1'b1);
    hm_u.xfer(8'hA4, 1'b1, q, a);
    cmp(a, 16'h0001);
    hm_u.cond(1'b0);
  endtask
  task automatic s_tri();
    wr(8'h01, 8'hFF);
    cmp(clk_out_oe, 16'h0000);
    cmp(host_freq_10khz, 16'h1770);
  endtask
  // second reset with the mode strap high: stops ignored, reference clock driven
  task automatic s_mode();
    nrst <= 1'b0;
    mode_strap_in <= 1'b1;
    hw_freq_strap <= 4'h9;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    host_stop_n <= 1'b0;
    bus_stop_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    cmp(reference_clock_oe, 16'h0001);
    cmp(clk_out_oe, 16'h0001);
    cmp(freq_code, 16'h0009);
    cmp(host_freq_10khz, 16'h2535);
    hi_cnt();
    cmp(h, 16'h0014);
    cmp(b, 16'h0014);
    cmp(r, 16'h0014);
  endtask
  // a hang costs a mismatch and ends the run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h2710)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk); // outputs left alone while settling, scaled down
    s_reset();
    s_stop();
    s_write();
    s_read();
    s_bad();
    s_tri();
    s_mode();
    summarize();
  end
endmodule // clock_gen_serial_ctrl_pm_tb
